// ---- cfg_readback.sv ----
// Purpose: Device-side TAP with config-in, config-out and shutdown paths.
// Assumes: tck, tms, tdi arrive asynchronously; ref_clk far faster than tck.
// Notes: Frame data comes from a same-clock memory read port.
`timescale 1ns/100ps
module cfg_readback #(
  parameter int FRAME_WORDS = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  output logic done,
  output logic [31:0] mem_addr,
  input wire logic [31:0] mem_data
);
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
    TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } tap_t;

  // Refuse a frame buffer with no words
  if (FRAME_WORDS < 1) begin : g_chk
    $error("FRAME_WORDS must be at least 1");
  end

  // Standard TAP transition on one TCK rise
  function automatic tap_t tap_next(input tap_t s, input logic m);
    unique case (s)
      TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EX2_DR : TAP_PAUSE_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EX2_IR : TAP_PAUSE_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
    endcase
  endfunction

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [2:0] tck_s_q;
  logic [1:0] tms_s_q, tdi_s_q;
  logic tck_rise, tck_fall, tms_v, tdi_v;

  // Two flops per pin, third tck flop for edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tck_s_q <= 3'h7; // Idle high: a false fall is harmless, a rise is not
      tms_s_q <= 2'h3;
      tdi_s_q <= 2'h0;
    end else begin
      tck_s_q <= {tck_s_q[1:0], tck};
      tms_s_q <= {tms_s_q[0], tms};
      tdi_s_q <= {tdi_s_q[0], tdi};
    end
  end

  assign tck_rise = tck_s_q[1] & ~tck_s_q[2];
  assign tck_fall = ~tck_s_q[1] & tck_s_q[2];
  assign tms_v = tms_s_q[1];
  assign tdi_v = tdi_s_q[1];

  // ****************************************
  // TAP controller and instruction register
  // ****************************************
  tap_t tap_q, tap_d;
  logic [9:0] ir_q, ir_d, ir_sr_q, ir_sr_d;

  // State walk, capture, shift and update of the IR
  always_comb begin
    tap_d = tap_q;
    ir_d = ir_q;
    ir_sr_d = ir_sr_q;
    if (tck_rise) begin
      tap_d = tap_next(tap_q, tms_v);
      unique case (tap_q)
        TAP_TLR: ir_d = cfg_rb_pkg::IR_RESET_VAL;
        TAP_CAP_IR: ir_sr_d = cfg_rb_pkg::IR_CAPTURE;
        TAP_SHIFT_IR: ir_sr_d = {tdi_v, ir_sr_q[9:1]};
        TAP_UPD_IR: ir_d = ir_sr_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tap_q <= TAP_TLR;
      ir_q <= cfg_rb_pkg::IR_RESET_VAL;
      ir_sr_q <= cfg_rb_pkg::IR_CAPTURE;
    end else begin
      tap_q <= tap_d;
      ir_q <= ir_d;
      ir_sr_q <= ir_sr_d;
    end
  end

  // ****************************************
  // Packet input, flush pipeline, commands, shutdown
  // ****************************************
  logic [31:0] in_sr_q, in_sr_d, w;
  logic [4:0] in_cnt_q, in_cnt_d;
  logic [31:0] pipe_q [2];
  logic [31:0] pipe_d [2];
  logic [1:0] pv_q, pv_d;
  logic synced_q, synced_d, rb_mode_q, rb_mode_d, rd_hdr_q, rd_hdr_d;
  logic [10:0] wr_left_q, wr_left_d;
  logic [4:0] wr_reg_q, wr_reg_d;
  logic [31:0] frame_addr_q, frame_addr_d;
  logic arm_q, arm_d;
  logic [26:0] arm_cnt_q, arm_cnt_d;
  logic busy_q, busy_d, done_q, done_d;
  logic [3:0] sh_cnt_q, sh_cnt_d;

  // Words run through two stages; only a pushed-out word takes effect
  always_comb begin
    in_sr_d = in_sr_q;
    in_cnt_d = in_cnt_q;
    pipe_d = pipe_q;
    pv_d = pv_q;
    synced_d = synced_q;
    rb_mode_d = rb_mode_q;
    rd_hdr_d = rd_hdr_q;
    wr_left_d = wr_left_q;
    wr_reg_d = wr_reg_q;
    frame_addr_d = frame_addr_q;
    arm_d = 1'b0;
    arm_cnt_d = arm_cnt_q;
    busy_d = busy_q;
    done_d = done_q;
    sh_cnt_d = sh_cnt_q;
    w = pipe_q[1];
    if (tck_rise && tap_q == TAP_SHIFT_DR &&
        ir_q == cfg_rb_pkg::IR_CFG_IN) begin
      in_sr_d = {in_sr_q[30:0], tdi_v};
      in_cnt_d = in_cnt_q + 5'h01;
      if (in_cnt_q == 5'h1f) begin
        pipe_d[0] = {in_sr_q[30:0], tdi_v};
        pipe_d[1] = pipe_q[0];
        pv_d = {pv_q[0], 1'b1};
        if (pv_q[1]) begin
          if (!synced_q) begin
            synced_d = (w == cfg_rb_pkg::SYNC_WORD);
          end else if (wr_left_q != 11'h000) begin
            wr_left_d = wr_left_q - 11'h001;
            if (wr_reg_q == cfg_rb_pkg::REG_FRAME_ADDR) begin
              frame_addr_d = w;
            end else if (wr_reg_q == cfg_rb_pkg::REG_CMD &&
                         w == cfg_rb_pkg::CMD_READBACK_CFG) begin
              rb_mode_d = 1'b1;
            end else if (wr_reg_q == cfg_rb_pkg::REG_CMD &&
                         w == cfg_rb_pkg::CMD_CRC_RESET) begin
              rb_mode_d = 1'b0;
            end
          end else if (w[31:29] == cfg_rb_pkg::HDR_TYPE1) begin
            rd_hdr_d = 1'b0;
            if (w[28:27] == cfg_rb_pkg::OP_WRITE) begin
              wr_reg_d = w[17:13];
              wr_left_d = w[10:0];
            end else if (w[28:27] == cfg_rb_pkg::OP_READ &&
                         w[17:13] == cfg_rb_pkg::REG_FRAME_OUT &&
                         rb_mode_q) begin
              rd_hdr_d = 1'b1;
              arm_d = 1'b1;
              arm_cnt_d = {16'h0000, w[10:0]};
            end
          end else if (w[31:29] == cfg_rb_pkg::HDR_TYPE2 && rd_hdr_q) begin
            arm_d = 1'b1;
            arm_cnt_d = w[26:0];
          end
        end
      end
    end
    if (tck_rise && tap_q == TAP_CAP_DR) begin
      in_cnt_d = 5'h00;
    end
    if (tck_rise && tap_q == TAP_TLR) begin
      pv_d = 2'h0;
      synced_d = 1'b0;
      wr_left_d = 11'h000;
    end
    // Shutdown starts at update of its instruction, counts TCKs in idle
    if (tck_rise && tap_q == TAP_UPD_IR &&
        ir_sr_q == cfg_rb_pkg::IR_SHUTDOWN) begin
      busy_d = 1'b1;
      done_d = 1'b0;
      sh_cnt_d = 4'h0;
    end else if (tck_rise && busy_q && tap_d == TAP_RTI) begin
      sh_cnt_d = sh_cnt_q + 4'h1;
      if (sh_cnt_q + 4'h1 == cfg_rb_pkg::SHUTDOWN_TCKS) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_sr_q <= 32'h0;
      in_cnt_q <= 5'h00;
      pipe_q <= '{32'h0, 32'h0};
      pv_q <= 2'h0;
      synced_q <= 1'b0;
      rb_mode_q <= 1'b0;
      rd_hdr_q <= 1'b0;
      wr_left_q <= 11'h000;
      wr_reg_q <= 5'h00;
      frame_addr_q <= 32'h0;
      arm_q <= 1'b0;
      arm_cnt_q <= 27'h0;
      busy_q <= 1'b0;
      done_q <= cfg_rb_pkg::DONE_RESET;
      sh_cnt_q <= 4'h0;
    end else begin
      in_sr_q <= in_sr_d;
      in_cnt_q <= in_cnt_d;
      pipe_q <= pipe_d;
      pv_q <= pv_d;
      synced_q <= synced_d;
      rb_mode_q <= rb_mode_d;
      rd_hdr_q <= rd_hdr_d;
      wr_left_q <= wr_left_d;
      wr_reg_q <= wr_reg_d;
      frame_addr_q <= frame_addr_d;
      arm_q <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      sh_cnt_q <= sh_cnt_d;
    end
  end

  // ****************************************
  // Frame buffer, readback shifter and TDO
  // ****************************************
  logic [31:0] fbuf_q [FRAME_WORDS];
  logic [31:0] fbuf_d [FRAME_WORDS];
  logic [31:0] out_sr_q, out_sr_d, addr_q, addr_d;
  logic [4:0] out_cnt_q, out_cnt_d;
  logic [26:0] rd_left_q, rd_left_d;
  logic [15:0] rb_idx_q, rb_idx_d;
  logic load, tdo_q, tdo_d, oe_n_q, oe_n_d;

  // Memory words enter the buffer tail; the shifter takes the head
  always_comb begin
    fbuf_d = fbuf_q;
    out_sr_d = out_sr_q;
    out_cnt_d = out_cnt_q;
    rd_left_d = rd_left_q;
    addr_d = addr_q;
    rb_idx_d = rb_idx_q;
    tdo_d = tdo_q;
    oe_n_d = oe_n_q;
    load = tck_rise && ir_q == cfg_rb_pkg::IR_CFG_OUT &&
           (tap_q == TAP_CAP_DR ||
            (tap_q == TAP_SHIFT_DR && out_cnt_q == 5'h1f));
    if (arm_q) begin
      for (int i = 0; i < FRAME_WORDS; i++) begin
        fbuf_d[i] = 32'h0;
      end
      rd_left_d = arm_cnt_q;
      addr_d = frame_addr_q;
      rb_idx_d = 16'h0000;
    end else if (load) begin
      out_cnt_d = 5'h00;
      out_sr_d = 32'h0;
      if (rd_left_q != 27'h0) begin
        out_sr_d = fbuf_q[0];
        for (int i = 0; i < FRAME_WORDS - 1; i++) begin
          fbuf_d[i] = fbuf_q[i + 1];
        end
        fbuf_d[FRAME_WORDS - 1] = mem_data;
        addr_d = addr_q + 32'h1;
        rd_left_d = rd_left_q - 27'h1;
        if (rb_idx_q != 16'hffff) begin
          rb_idx_d = rb_idx_q + 16'h0001;
        end
      end
    end else if (tck_rise && tap_q == TAP_SHIFT_DR) begin
      out_sr_d = {out_sr_q[30:0], 1'b0};
      out_cnt_d = out_cnt_q + 5'h01;
    end
    // TDO changes on the falling TCK edge
    if (tck_fall) begin
      oe_n_d = !(tap_q == TAP_SHIFT_DR || tap_q == TAP_SHIFT_IR);
      if (tap_q == TAP_SHIFT_IR) begin
        tdo_d = ir_sr_q[0];
      end else if (ir_q == cfg_rb_pkg::IR_CFG_OUT) begin
        tdo_d = out_sr_q[31];
      end else begin
        tdo_d = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fbuf_q <= '{default: 32'h0};
      out_sr_q <= 32'h0;
      out_cnt_q <= 5'h00;
      rd_left_q <= 27'h0;
      addr_q <= 32'h0;
      rb_idx_q <= 16'h0000;
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      fbuf_q <= fbuf_d;
      out_sr_q <= out_sr_d;
      out_cnt_q <= out_cnt_d;
      rd_left_q <= rd_left_d;
      addr_q <= addr_d;
      rb_idx_q <= rb_idx_d;
      tdo_q <= tdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe_n = oe_n_q;
  assign done = done_q;
  assign mem_addr = addr_q;

  // ****************************************
  // Assertions
  // ****************************************
  logic [2:0] ones_q;

  // Consecutive TMS-high rises, for the reset check
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ones_q <= 3'h0;
    end else if (tck_rise) begin
      ones_q <= !tms_v ? 3'h0 :
                (ones_q == 3'h7 ? ones_q : ones_q + 3'h1);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_tlr_reach;
    ones_q >= cfg_rb_pkg::TLR_ONES |-> tap_q == TAP_TLR;
  endproperty
  a_tlr_reach: assert property (p_tlr_reach)
    else $error("five TMS highs did not reach reset state");

  property p_ir_update;
    tck_rise && tap_q == TAP_UPD_IR |=> ir_q == $past(ir_sr_q);
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction not updated");

  property p_done_low;
    busy_q |-> !done_q;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done high during shutdown");

  property p_shut_len;
    busy_q && tck_rise && tap_d == TAP_RTI && sh_cnt_q == 4'hb &&
      tap_q != TAP_UPD_IR
      |=> !busy_q ##1 !done_q;
  endproperty
  a_shut_len: assert property (p_shut_len)
    else $error("shutdown not ended after twelve idle TCKs");

  property p_shut_hold;
    busy_q && sh_cnt_q < 4'hb |=> busy_q;
  endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("shutdown ended early");

  property p_dummy_frame;
    load && !arm_q && rd_left_q != 27'h0 && rb_idx_q < FRAME_WORDS
      |=> out_sr_q == 32'h0;
  endproperty
  a_dummy_frame: assert property (p_dummy_frame)
    else $error("first frame was not dummy data");

  property p_tdo_data;
    tck_fall && tap_q == TAP_SHIFT_DR && ir_q == cfg_rb_pkg::IR_CFG_OUT
      |=> tdo_q == $past(out_sr_q[31]) && !oe_n_q;
  endproperty
  a_tdo_data: assert property (p_tdo_data)
    else $error("readback bit not driven on tdo");

  c_shutdown: cover property ($fell(busy_q));
  c_armed: cover property (arm_q && arm_cnt_q != 27'h0);
  c_real_word: cover property (load && rb_idx_q >= FRAME_WORDS);
endmodule // cfg_readback

// ---- cfg_rb_pkg.sv ----
// Purpose: Shared constants for the boundary-scan configuration readback.
// Assumes: 10-bit instruction register, 32-bit configuration words.
// Notes: Instruction codes carry the final shifted bit as their MSB.
package cfg_rb_pkg;
  // ****************************************
  // Instruction register
  // ****************************************
  localparam int IR_LEN = 10;
  localparam logic [9:0] IR_CFG_IN = 10'h3c5;
  localparam logic [9:0] IR_CFG_OUT = 10'h3c4;
  localparam logic [9:0] IR_SHUTDOWN = 10'h3cd;
  localparam logic [9:0] IR_CAPTURE = 10'h001;
  localparam logic [9:0] IR_RESET_VAL = 10'h3ff;
  // ****************************************
  // Packet words and fields
  // ****************************************
  localparam logic [31:0] SYNC_WORD = 32'haa995566;
  localparam int HDR_TYPE_MSB = 31;
  localparam int HDR_TYPE_LSB = 29;
  localparam int HDR_OP_MSB = 28;
  localparam int HDR_OP_LSB = 27;
  localparam int HDR_REG_MSB = 17;
  localparam int HDR_REG_LSB = 13;
  localparam int HDR_CNT1_MSB = 10;
  localparam int HDR_CNT2_MSB = 26;
  localparam logic [2:0] HDR_TYPE1 = 3'h1;
  localparam logic [2:0] HDR_TYPE2 = 3'h2;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [4:0] REG_FRAME_ADDR = 5'h01;
  localparam logic [4:0] REG_FRAME_OUT = 5'h03;
  localparam logic [4:0] REG_CMD = 5'h04;
  localparam logic [31:0] CMD_CRC_RESET = 32'h00000007;
  localparam logic [31:0] CMD_READBACK_CFG = 32'h00000004;
  // ****************************************
  // Timing and reset values
  // ****************************************
  localparam logic [3:0] SHUTDOWN_TCKS = 4'hc;
  localparam logic [2:0] TLR_ONES = 3'h5;
  localparam logic DONE_RESET = 1'b1;
endpackage

// ---- jtag_host_model.sv ----
// Purpose: Host side of the boundary-scan port for the readback bench.
// Assumes: tck period 16 ref_clk (160 ns); tck stands still between calls.
// Notes: tms/tdi change only while tck is low, on a ref_clk edge.
`timescale 1ns/100ps
module jtag_host_model (
  input wire logic ref_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // ****************************************
  // Bit cycle
  // ****************************************
  // Idle levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One tck period: fall, set tms/tdi, sample tdo, rise
  task automatic bit_io(input logic tms_v, input logic tdi_v,
                        output logic tdo_v, output logic oe_v);
    @(posedge ref_clk);
    tck <= 1'b0;
    tms <= tms_v;
    tdi <= tdi_v;
    repeat (8) @(posedge ref_clk);
    tdo_v = tdo;
    oe_v = tdo_oe_n;
    tck <= 1'b1;
    repeat (7) @(posedge ref_clk);
  endtask

  // ****************************************
  // Protocol steps
  // ****************************************
  // Walk the TAP, tms bits lsb first; tdi toggles as filler
  task automatic nav(input logic [15:0] bits, input int n);
    logic t;
    logic o;
    for (int i = 0; i < n; i++) begin
      bit_io(bits[i], ~tdi, t, o);
    end
  endtask

  // Five ones on tms reach Test-Logic-Reset
  task automatic tap_reset();
    nav(16'h001f, 5);
  endtask

  // Instruction lsb first, msb while leaving Shift-IR
  task automatic load_ir(input logic [9:0] code, output logic [9:0] cap);
    logic t;
    logic o;
    for (int i = 0; i < 10; i++) begin
      bit_io(i == 9, code[i], t, o);
      cap[i] = t;
    end
  endtask

  // Words msb first; the last lsb goes out while leaving Shift-DR
  task automatic shift_dr(input logic [31:0] words[$],
                          output logic [31:0] got[$]);
    logic t;
    logic o;
    logic [31:0] r;
    got = {};
    for (int w = 0; w < words.size(); w++) begin
      for (int b = 31; b >= 0; b--) begin
        bit_io(w == words.size() - 1 && b == 0, words[w][b], t, o);
        r[b] = t;
      end
      got.push_back(r);
    end
  endtask
endmodule // jtag_host_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the configuration readback block.
// Assumes: Host model drives the TAP; memory word is address ^ a pattern.
// Notes: Frame buffer shrunk to two words to keep the run short.
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected %s exp %h got %h", nm, exp, got); \
    end \
  end
module tb_top;
  // ****************************************
  // Signals and settings
  // ****************************************
  typedef struct packed {logic tms; logic oe_n;} row_t;
  localparam int FW = 2;
  localparam int NRD = 5;
  localparam logic [31:0] START = 32'h00000010;
  localparam logic [31:0] SCRAMBLE = 32'h5ca1ab1e;
  localparam logic [31:0] NOOP = 32'h20000000;
  localparam row_t ROWS [17] = '{'{1'b0, 1'b1}, '{1'b1, 1'b1},
    '{1'b0, 1'b1}, '{1'b0, 1'b1}, '{1'b1, 1'b0}, '{1'b0, 1'b1},
    '{1'b1, 1'b1}, '{1'b0, 1'b1}, '{1'b1, 1'b0}, '{1'b1, 1'b1},
    '{1'b1, 1'b1}, '{1'b1, 1'b1}, '{1'b0, 1'b1}, '{1'b0, 1'b1},
    '{1'b1, 1'b0}, '{1'b1, 1'b1}, '{1'b0, 1'b1}};
  logic ref_clk;
  logic rst_n;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic done;
  logic [31:0] mem_addr;
  logic [31:0] mem_data;
  logic [9:0] cap;
  logic [31:0] wq[$];
  logic [31:0] rq[$];
  logic t;
  logic o;
  int mismatches = 0;
  int total_checks = 0;

  // Memory word follows its address
  assign mem_data = mem_addr ^ SCRAMBLE;

  cfg_readback #(.FRAME_WORDS(FW)) u_cfg_readback (.ref_clk(ref_clk),
    .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .done(done), .mem_addr(mem_addr),
    .mem_data(mem_data));

  jtag_host_model u_jtag_host_model (.ref_clk(ref_clk), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  // ****************************************
  // Clock, verdict and watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Print counts and verdict, then stop
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cut a hang short well past the expected 15k cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    `CHK("done in reset", 1'b1, done)
    `CHK("oe_n in reset", 1'b1, tdo_oe_n)
    `CHK("mem_addr in reset", 32'h0, mem_addr)
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK("oe_n after release", 1'b1, tdo_oe_n)
    `CHK("tdo after release", 1'b0, tdo)
    u_jtag_host_model.tap_reset();
    // TAP walk through pause and both shift states
    for (int i = 0; i < 17; i++) begin
      u_jtag_host_model.bit_io(ROWS[i].tms, 1'b1, t, o);
      `CHK("oe_n row", ROWS[i].oe_n, o)
    end
    `CHK("done after walk", 1'b1, done)
    // First stream: reset the CRC
    u_jtag_host_model.tap_reset();
    u_jtag_host_model.nav(16'h0006, 5);
    u_jtag_host_model.load_ir(cfg_rb_pkg::IR_CFG_IN, cap);
    `CHK("ir capture", cfg_rb_pkg::IR_CAPTURE, cap)
    u_jtag_host_model.nav(16'h0003, 4);
    wq = '{32'hffffffff, cfg_rb_pkg::SYNC_WORD, NOOP, 32'h30008001,
      cfg_rb_pkg::CMD_CRC_RESET, NOOP, NOOP};
    u_jtag_host_model.shift_dr(wq, rq);
    // Shutdown and twelve idle cycles
    u_jtag_host_model.nav(16'h0007, 5);
    u_jtag_host_model.load_ir(cfg_rb_pkg::IR_SHUTDOWN, cap);
    `CHK("done before update", 1'b1, done)
    u_jtag_host_model.nav(16'h0001, 2);
    `CHK("done at shutdown", 1'b0, done)
    u_jtag_host_model.nav(16'h0000, 12);
    `CHK("done after idle", 1'b0, done)
    // Second stream: arm readback from START
    u_jtag_host_model.nav(16'h0003, 4);
    u_jtag_host_model.load_ir(cfg_rb_pkg::IR_CFG_IN, cap);
    u_jtag_host_model.nav(16'h0003, 4);
    wq = '{32'hffffffff, cfg_rb_pkg::SYNC_WORD, NOOP, 32'h30008001,
      cfg_rb_pkg::CMD_READBACK_CFG, 32'h30002001, START};
    wq.push_back(32'h28006000);
    wq.push_back(32'h48000000 | 32'(FW + NRD));
    wq.push_back(NOOP);
    wq.push_back(NOOP);
    u_jtag_host_model.shift_dr(wq, rq);
    // Readback: dummy frame first, then memory words
    u_jtag_host_model.nav(16'h0007, 5);
    u_jtag_host_model.load_ir(cfg_rb_pkg::IR_CFG_OUT, cap);
    u_jtag_host_model.nav(16'h0003, 4);
    wq = '{NOOP, NOOP, NOOP, NOOP, NOOP, NOOP, NOOP};
    u_jtag_host_model.shift_dr(wq, rq);
    `CHK("mem_addr at end", START + 32'(FW + NRD), mem_addr)
    for (int k = 0; k < FW; k++) begin
      `CHK("dummy word", 32'h0, rq[k])
    end
    for (int k = 0; k < NRD; k++) begin
      `CHK("frame word", (START + 32'(k)) ^ SCRAMBLE, rq[FW + k])
    end
    u_jtag_host_model.tap_reset();
    `CHK("done after tap reset", 1'b0, done)
    `CHK("oe_n after tap reset", 1'b1, tdo_oe_n)
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK("done after reset", 1'b1, done)
    `CHK("mem_addr after reset", 32'h0, mem_addr)
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK("done after release", 1'b1, done)
    `CHK("oe_n after 2nd release", 1'b1, tdo_oe_n)
    // TAP must answer again after the mid-run reset
    u_jtag_host_model.tap_reset();
    u_jtag_host_model.nav(16'h0006, 5);
    u_jtag_host_model.load_ir(cfg_rb_pkg::IR_CFG_IN, cap);
    `CHK("ir capture after reset", cfg_rb_pkg::IR_CAPTURE, cap)
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end
endmodule // tb_top
